// File: hw/bsct_fifo.sv
// Parameterised valid/ready FIFO that holds gathered write words.
`timescale 1ns/1ns
module bsct_fifo #(
  parameter int WIDTH = 94,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wp_reg;
  logic [AW:0]      rp_reg;
  logic             full;
  logic             empty;

  // The extra pointer bit tells a full ring from an empty one.
  assign full          = (wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]);
  assign empty         = (wp_reg == rp_reg);
  assign in_ready_out  = ~full;
  assign out_valid_out = ~empty;
  assign out_data_out  = mem[rp_reg[AW-1:0]];

  // Storage needs no reset; only the pointers define what is valid.
  always_ff @(posedge clk_in) begin
    if (in_valid_in && !full) begin
      mem[wp_reg[AW-1:0]] <= in_data_in;
    end
  end

  // Pointers advance on each accepted push and pop.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      if (in_valid_in && !full) begin
        wp_reg <= wp_reg + 1'b1;
      end
      if (out_ready_in && !empty) begin
        rp_reg <= rp_reg + 1'b1;
      end
    end
  end

endmodule

// File: hw/bsct_pkg.sv
// Constants and types shared by the burst-of-four SRAM command and beat timing block.
package bsct_pkg;

  // Pin and word widths of the x18 organisation.
  localparam int DATA_W   = 18;
  localparam int HALF_W   = 9;
  localparam int NUM_HALF = 2;
  localparam int BEATS    = 4;
  localparam int WORD_W   = DATA_W * BEATS;
  localparam int ADDR_W   = 22;

  // Array depth kept small; only the low address bits select a word.
  localparam int ARR_AW    = 8;
  localparam int ARR_DEPTH = 1 << ARR_AW;

  // Write word FIFO between beat gathering and the array.
  localparam int FIFO_W     = ADDR_W + WORD_W;
  localparam int FIFO_DEPTH = 32;

  // Read latency in master clock cycles and depth of the command history.
  localparam int READ_LAT = 3;
  localparam int HIST_N   = READ_LAT + 1;

  // Every pin passes the same two-flop synchroniser.
  localparam int SYNC_W = 1 + 2 * NUM_HALF + 3 + ADDR_W + DATA_W;

  // Values after reset.
  localparam logic [DATA_W-1:0] Q_RST  = 18'h00000;
  localparam logic              OE_RST = 1'b0;
  localparam logic [WORD_W-1:0] WORD_RST = 72'h000000000000000000;

  // Command decoded at each master clock rise.
  typedef enum logic [1:0] {
    BSCT_NOP   = 2'b00,
    BSCT_WRITE = 2'b01,
    BSCT_READ  = 2'b10
  } bsct_cmd_t;

endpackage

// File: hw/bsct_sram.sv
// Command decode, write beat capture and read beat timing of a burst-of-four SRAM.
//
// Summary of operation
// - Each master clock rise decodes selects: read wins, then write, else no operation.
// - Write at n takes beats at write-clock rises n+1, n+1.5, n+2, n+2.5.
// - Read at n drives beats at echo rises n+3, n+3.5, n+4, n+4.5.
// - A previous write's third and fourth beats are captured whatever the current command.
// - A previous read's third and fourth beats fill the slot after a write or no-op.
// - Termination on: idle slot three cycles after write or no-op drives zeros.
// - Termination off: that idle slot puts the read data in high impedance.
// - Master clock latches address and selects; each write clock pair latches its half.
`timescale 1ns/1ns
module bsct_sram
  import bsct_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                master_clock_in,
  input  wire logic [NUM_HALF-1:0] write_data_clock_in,
  input  wire logic [NUM_HALF-1:0] write_data_clock_n_in,
  input  wire logic                read_sel_n_in,
  input  wire logic                write_sel_n_in,
  input  wire logic [ADDR_W-1:0]   sync_address_in,
  input  wire logic [DATA_W-1:0]   write_data_in,
  input  wire logic                write_data_termination_in,
  output logic [DATA_W-1:0]        read_data_out,
  output logic                     read_data_oe_out,
  output logic [NUM_HALF-1:0]      echo_clock_out,
  output logic [NUM_HALF-1:0]      echo_clock_n_out
);

  logic [SYNC_W-1:0]   pin_vec;
  logic [SYNC_W-1:0]   s1_reg;
  logic [SYNC_W-1:0]   s2_reg;
  logic [4:0]          prev_reg;
  logic                mc;
  logic [1:0]          kd;
  logic [1:0]          kdn;
  logic                rsel_n;
  logic                wsel_n;
  logic                term;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wd;
  logic                mc_rise;
  logic                mc_fall;
  logic [1:0]          kr_reg;
  logic [1:0]          knr_reg;
  logic [DATA_W-1:0]   wd_reg;
  bsct_cmd_t           cmd_cur;
  bsct_cmd_t           hist_reg [HIST_N];
  logic [WORD_W-1:0]   rdw_reg [HIST_N];
  logic [WORD_W-1:0]   mem [ARR_DEPTH];
  logic [WORD_W-1:0]   fetch_word;
  logic [2:0]          wp_reg;
  logic [ADDR_W-1:0]   wa_reg [3];
  logic [35:0]         wb_reg [NUM_HALF];
  logic [WORD_W-1:0]   gathered;
  logic                push_vld_reg;
  logic [FIFO_W-1:0]   push_data_reg;
  logic                push_ready;
  logic                drain_vld;
  logic                drain_ready;
  logic [FIFO_W-1:0]   drain_data;
  logic [ADDR_W-1:0]   drain_addr;
  logic [DATA_W-1:0]   q_reg;
  logic [DATA_W-1:0]   q2_reg;
  logic                oe_reg;
  logic [1:0]          echo_reg;

  // Every pin comes from the controller's clocks, so all of them pass two flops.
  assign pin_vec = {master_clock_in, write_data_clock_in, write_data_clock_n_in, read_sel_n_in,
                    write_sel_n_in, write_data_termination_in, sync_address_in, write_data_in};

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= pin_vec;
      s2_reg <= s1_reg;
    end
  end

  // Fields of the synchronised pin vector.
  assign mc     = s2_reg[47];
  assign kd     = s2_reg[46:45];
  assign kdn    = s2_reg[44:43];
  assign rsel_n = s2_reg[42];
  assign wsel_n = s2_reg[41];
  assign term   = s2_reg[40];
  assign addr   = s2_reg[39:18];
  assign wd     = s2_reg[17:0];

  // Clock levels one cycle older, for edge detection.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prev_reg <= '0;
    end else begin
      prev_reg <= {mc, kd, kdn};
    end
  end

  assign mc_rise = mc & ~prev_reg[4];
  assign mc_fall = ~mc & prev_reg[4];

  // Write clock edges and data are held one cycle so that a write clock edge seen in the
  // same cycle as a master rise already sees the advanced write stage.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kr_reg  <= '0;
      knr_reg <= '0;
      wd_reg  <= '0;
    end else begin
      kr_reg  <= kd & ~prev_reg[3:2];
      knr_reg <= kdn & ~prev_reg[1:0];
      wd_reg  <= wd;
    end
  end

  // Read select wins over write select; both high is no operation.
  always_comb begin
    if (!rsel_n) begin
      cmd_cur = BSCT_READ;
    end else if (!wsel_n) begin
      cmd_cur = BSCT_WRITE;
    end else begin
      cmd_cur = BSCT_NOP;
    end
  end

  assign fetch_word = mem[addr[ARR_AW-1:0]];

  // Command history with the fetched read word; index k is the command k rises ago.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int k = 0; k < HIST_N; k++) begin
        hist_reg[k] <= BSCT_NOP;
        rdw_reg[k]  <= WORD_RST;
      end
    end else if (mc_rise) begin
      hist_reg[0] <= cmd_cur;
      rdw_reg[0]  <= (cmd_cur == BSCT_READ) ? fetch_word : WORD_RST;
      for (int k = 1; k < HIST_N; k++) begin
        hist_reg[k] <= hist_reg[k-1];
        rdw_reg[k]  <= rdw_reg[k-1];
      end
    end
  end

  // Write stages: bit 0 just sampled, bit 1 taking beats 1-2, bit 2 taking beats 3-4.
  // The address is latched only with a write, so a no-op address never matters.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wp_reg <= '0;
      for (int k = 0; k < 3; k++) begin
        wa_reg[k] <= '0;
      end
    end else if (mc_rise) begin
      wp_reg <= {wp_reg[1:0], cmd_cur == BSCT_WRITE};
      if (cmd_cur == BSCT_WRITE) begin
        wa_reg[0] <= addr;
      end
      wa_reg[1] <= wa_reg[0];
      wa_reg[2] <= wa_reg[1];
    end
  end

  // Each half gathers its own beats from its own write clock pair. Beats 3 and 4 are taken
  // in stage 2 no matter what the current command is.
  for (genvar h = 0; h < NUM_HALF; h++) begin : g_half
    always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        wb_reg[h] <= '0;
      end else if (wp_reg[1]) begin
        if (kr_reg[h]) begin
          wb_reg[h][8:0] <= wd_reg[h*HALF_W +: HALF_W];
        end
        if (knr_reg[h]) begin
          wb_reg[h][17:9] <= wd_reg[h*HALF_W +: HALF_W];
        end
      end else if (wp_reg[2]) begin
        if (kr_reg[h]) begin
          wb_reg[h][26:18] <= wd_reg[h*HALF_W +: HALF_W];
        end
        if (knr_reg[h]) begin
          wb_reg[h][35:27] <= wd_reg[h*HALF_W +: HALF_W];
        end
      end
    end
  end

  // Beat k fills bits 18k..18k+17 of the array word; half 0 is the low nine bits.
  always_comb begin
    gathered = WORD_RST;
    for (int k = 0; k < BEATS; k++) begin
      gathered[k*DATA_W +: HALF_W]          = wb_reg[0][k*HALF_W +: HALF_W];
      gathered[k*DATA_W + HALF_W +: HALF_W] = wb_reg[1][k*HALF_W +: HALF_W];
    end
  end

  // The whole word goes to the FIFO at the rise that ends stage 2. It waits here while the
  // FIFO is full; back-to-back writes are illegal, so one word of holding is enough.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      push_vld_reg  <= 1'b0;
      push_data_reg <= '0;
    end else if (mc_rise && wp_reg[2]) begin
      push_vld_reg  <= 1'b1;
      push_data_reg <= {wa_reg[2], gathered};
    end else if (push_ready) begin
      push_vld_reg <= 1'b0;
    end
  end

  // A read fetch owns the array port, so the drain stalls in that cycle.
  assign drain_ready = ~(mc_rise && cmd_cur == BSCT_READ);
  assign drain_addr  = drain_data[FIFO_W-1 -: ADDR_W];

  bsct_fifo #(
    .WIDTH (FIFO_W),
    .DEPTH (FIFO_DEPTH)
  ) u_wfifo (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .in_valid_in   (push_vld_reg),
    .in_ready_out  (push_ready),
    .in_data_in    (push_data_reg),
    .out_valid_out (drain_vld),
    .out_ready_in  (drain_ready),
    .out_data_out  (drain_data)
  );

  // All four beats land in the array in one write.
  always_ff @(posedge clk_in) begin
    if (drain_vld && drain_ready) begin
      mem[drain_addr[ARR_AW-1:0]] <= drain_data[WORD_W-1:0];
    end
  end

  // Output slot of the cycle starting at this rise: a read three rises ago gives beats 1-2,
  // else a read four rises ago gives beats 3-4, else the idle level set by termination.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q_reg  <= Q_RST;
      q2_reg <= Q_RST;
      oe_reg <= OE_RST;
    end else if (mc_rise) begin
      if (hist_reg[READ_LAT-1] == BSCT_READ) begin
        q_reg  <= rdw_reg[READ_LAT-1][17:0];
        q2_reg <= rdw_reg[READ_LAT-1][35:18];
        oe_reg <= 1'b1;
      end else if (hist_reg[READ_LAT] == BSCT_READ) begin
        q_reg  <= rdw_reg[READ_LAT][53:36];
        q2_reg <= rdw_reg[READ_LAT][71:54];
        oe_reg <= 1'b1;
      end else begin
        q_reg  <= Q_RST;
        q2_reg <= Q_RST;
        oe_reg <= term;
      end
    end else if (mc_fall) begin
      q_reg <= q2_reg;
    end
  end

  // Echo clocks follow the master clock with the same delay as the read data.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      echo_reg <= '0;
    end else begin
      echo_reg <= {NUM_HALF{mc}};
    end
  end

  assign read_data_out    = q_reg;
  assign read_data_oe_out = oe_reg;
  assign echo_clock_out   = echo_reg;
  assign echo_clock_n_out = ~echo_reg;

  a_decode_read_wins: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && !rsel_n |=> hist_reg[0] == BSCT_READ)
    else $error("read select low did not decode as a read");

  a_decode_nop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && rsel_n && wsel_n |=> hist_reg[0] == BSCT_NOP && !wp_reg[0])
    else $error("both selects high did not decode as no operation");

  a_write_first_beat: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    kr_reg[0] && wp_reg[1] && !mc_rise |=> wb_reg[0][8:0] == $past(wd_reg[8:0]))
    else $error("first write beat not captured");

  a_write_tail_beat: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    knr_reg[1] && wp_reg[2] && !mc_rise |=> wb_reg[1][35:27] == $past(wd_reg[17:9]))
    else $error("fourth write beat of upper half not captured");

  a_read_head_slot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && hist_reg[2] == BSCT_READ |=> oe_reg && q_reg == $past(rdw_reg[2][17:0]))
    else $error("first read beat not driven three cycles after the read");

  a_read_tail_slot: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && hist_reg[2] != BSCT_READ && hist_reg[3] == BSCT_READ
    |=> oe_reg && q_reg == $past(rdw_reg[3][53:36]))
    else $error("third read beat missing after a following write or no-op");

  a_idle_driven_low: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && hist_reg[2] != BSCT_READ && hist_reg[3] != BSCT_READ && term
    |=> oe_reg && q_reg == Q_RST)
    else $error("idle slot not driven low with termination on");

  a_idle_high_z: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && hist_reg[2] != BSCT_READ && hist_reg[3] != BSCT_READ && !term |=> !oe_reg)
    else $error("idle slot not released with termination off");

  a_fetch_word: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && cmd_cur == BSCT_READ |=> rdw_reg[0] == $past(fetch_word))
    else $error("read did not fetch the addressed array word");

  a_word_push: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise && wp_reg[2] |=> push_vld_reg && push_data_reg[FIFO_W-1 -: ADDR_W] == $past(wa_reg[2]))
    else $error("gathered write word not pushed with its address");

  a_echo_follows: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mc_rise |=> echo_clock_out == 2'h3 && echo_clock_n_out == 2'h0)
    else $error("echo clocks not aligned to the master clock rise");

endmodule

// File: verification/bsct_ctl_model.sv
// Memory controller model that drives commands and write beats on the link pins.
`timescale 1ns/1ns
module bsct_ctl_model
  import bsct_pkg::*;
  import bsct_vpkg::*;
(
  input  wire logic           start_in,
  output logic                master_clock_out,
  output logic [NUM_HALF-1:0] write_data_clock_out,
  output logic [NUM_HALF-1:0] write_data_clock_n_out,
  output logic                read_sel_n_out,
  output logic                write_sel_n_out,
  output logic [ADDR_W-1:0]   sync_address_out,
  output logic [DATA_W-1:0]   write_data_out,
  output logic                write_data_termination_out
);
  bsct_vcmd_t      cq[$];
  logic [DATA_W:0] exq[$];
  bsct_vcmd_t      hist[0:4];
  bsct_vcmd_t      cur;

  // Read wins over write; both selects high is a no-operation.
  function automatic logic is_rd(bsct_vcmd_t c);
    return !c.rd_n;
  endfunction

  function automatic logic is_wr(bsct_vcmd_t c);
    return c.rd_n && !c.wr_n;
  endfunction

  // Present the beat due at the next data clock edge; an unused bus shows the inverse of its last value.
  task automatic put_beat(input int o);
    if (is_wr(hist[o])) write_data_out = hist[o].word[o*DATA_W +: DATA_W];
    else if (is_wr(hist[o+1])) write_data_out = hist[o+1].word[(o+2)*DATA_W +: DATA_W];
    else write_data_out = ~write_data_out;
  endtask

  // Note the two halves of the read slot that this rise opens.
  task automatic note_slot();
    if (is_rd(hist[3])) begin
      exq.push_back({1'b1, hist[3].word[0 +: DATA_W]});
      exq.push_back({1'b1, hist[3].word[DATA_W +: DATA_W]});
    end else if (is_rd(hist[4])) begin
      exq.push_back({1'b1, hist[4].word[2*DATA_W +: DATA_W]});
      exq.push_back({1'b1, hist[4].word[3*DATA_W +: DATA_W]});
    end else begin
      exq.push_back({hist[0].term, {DATA_W{1'b0}}});
      exq.push_back({hist[0].term, {DATA_W{1'b0}}});
    end
  endtask

  // Free-running master clock; commands change at the fall, beats a quarter cycle before their edge.
  initial begin
    master_clock_out = 1'b0;
    write_data_clock_out = '0;
    write_data_clock_n_out = '1;
    read_sel_n_out = 1'b1;
    write_sel_n_out = 1'b1;
    sync_address_out = '0;
    write_data_out = '0;
    write_data_termination_out = 1'b1;
    cur = '{rd_n: 1'b1, wr_n: 1'b1, term: 1'b1, default: '0};
    for (int i = 0; i < 5; i++) hist[i] = cur;
    wait (start_in === 1'b1);
    #7;
    forever begin
      if (cq.size() > 0) cur = cq.pop_front();
      else begin
        cur.rd_n = 1'b1;
        cur.wr_n = 1'b1;
        cur.addr = ~cur.addr;
      end
      read_sel_n_out = cur.rd_n;
      write_sel_n_out = cur.wr_n;
      sync_address_out = cur.addr;
      write_data_termination_out = cur.term;
      #31 put_beat(0);
      #31 master_clock_out = 1'b1;
      write_data_clock_out = '1;
      write_data_clock_n_out = '0;
      for (int i = 4; i > 0; i--) hist[i] = hist[i-1];
      hist[0] = cur;
      note_slot();
      #31 put_beat(1);
      #32 master_clock_out = 1'b0;
      write_data_clock_out = '0;
      write_data_clock_n_out = '1;
    end
  end
endmodule

// File: verification/bsct_vpkg.sv
// Command record shared by the controller model and the bench.
package bsct_vpkg;
  import bsct_pkg::*;

  // One master clock cycle of the controller: raw selects, termination, address, word.
  typedef struct packed {
    logic              rd_n;
    logic              wr_n;
    logic              term;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] word;
  } bsct_vcmd_t;
endpackage

// File: verification/tb_bsct_sram.sv
// Self-checking bench for the SRAM command and beat timing block, write FIFO seen through the top.
`timescale 1ns/1ns
module tb_bsct_sram
  import bsct_pkg::*;
  import bsct_vpkg::*;
;
  logic                clk_in, rst_n_in, start, mc, rsel_n, wsel_n, term, oe, echo_seen;
  logic [NUM_HALF-1:0] wclk, wclk_n, echo, echo_n;
  logic [ADDR_W-1:0]   addr;
  logic [DATA_W-1:0]   wd, rd;
  logic [FIFO_W-1:0]   fq[$];
  logic [WORD_W-1:0]   mem[ARR_DEPTH];
  logic [31:0]         xs_state = 32'h00000022;
  int                  last_wr[ARR_DEPTH];
  int                  err_count, num_checks, n_cmd, got, n_wr;

  bsct_sram uut (.clk_in(clk_in), .rst_n_in(rst_n_in), .master_clock_in(mc), .write_data_clock_in(wclk),
    .write_data_clock_n_in(wclk_n), .read_sel_n_in(rsel_n), .write_sel_n_in(wsel_n), .sync_address_in(addr),
    .write_data_in(wd), .write_data_termination_in(term), .read_data_out(rd), .read_data_oe_out(oe),
    .echo_clock_out(echo), .echo_clock_n_out(echo_n));
  bsct_ctl_model ctl (.start_in(start), .master_clock_out(mc), .write_data_clock_out(wclk),
    .write_data_clock_n_out(wclk_n), .read_sel_n_out(rsel_n), .write_sel_n_out(wsel_n),
    .sync_address_out(addr), .write_data_out(wd), .write_data_termination_out(term));

  // Free-running 100 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  function logic [31:0] xs();
    xs_state ^= xs_state << 13;
    xs_state ^= xs_state >> 17;
    xs_state ^= xs_state << 5;
    return xs_state;
  endfunction

  task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Queue one command; the bench's own array copy supplies what a read must return.
  task automatic push(input logic r_n, input logic w_n, input logic t, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] w);
    bsct_vcmd_t c;
    int i;
    i = int'(a[ARR_AW-1:0]);
    c = '{rd_n: r_n, wr_n: w_n, term: t, addr: a, word: w};
    if (!r_n) c.word = mem[i];
    else if (!w_n) begin
      mem[i] = w;
      last_wr[i] = n_cmd;
      fq.push_back({a, w});
      n_wr++;
    end
    ctl.cq.push_back(c);
    n_cmd++;
  endtask

  task automatic group_done(input string s);
    while (ctl.cq.size() != 0) @(negedge clk_in);
    repeat (80) @(negedge clk_in);
    $display("%s done: %0d checks, %0d mismatches", s, num_checks, err_count);
  endtask

  // Each echo edge opens a half slot; its data and drive enable must match the oldest note.
  always @(negedge clk_in) begin
    if (rst_n_in === 1'b1 && echo[0] !== echo_seen) begin
      echo_seen = echo[0];
      check("echo pair", 96'({echo, echo_n}), 96'({{2{echo_seen}}, {2{~echo_seen}}}));
      if (ctl.exq.size() == 0) check("slot note", 96'(0), 96'(1));
      else check("read slot", 96'({oe, rd}), 96'(ctl.exq.pop_front()));
    end
  end

  // Write words must leave the design's FIFO toward the array in command order, address included.
  always @(negedge clk_in) begin
    if (uut.drain_vld === 1'b1 && uut.drain_ready === 1'b1) begin
      if (fq.size() > 0) check("fifo word", 96'(uut.drain_data), 96'(fq.pop_front()));
      else check("fifo extra word", 96'(1), 96'(0));
      got++;
    end
  end

  // Watchdog: about 850 link cycles of 125 ns are expected, so 300 us leaves ample margin.
  initial begin
    #300000;
    err_count++;
    end_sim();
  end

  initial begin
    logic [31:0] r;
    logic [95:0] w;
    logic        rn, wn, pw;
    int          i, a;
    rst_n_in = 1'b0;
    start = 1'b0;
    echo_seen = 1'b0;
    pw = 1'b0;
    for (i = 0; i < ARR_DEPTH; i++) last_wr[i] = -100;
    repeat (5) @(negedge clk_in);
    rst_n_in = 1'b1;
    start = 1'b1;
    // Preload every word, a no-operation between writes, termination alternating.
    for (a = 0; a < ARR_DEPTH; a++) begin
      r = xs();
      w = {xs(), xs(), xs()};
      push(1'b1, 1'b0, a[0], {r[13:0], a[7:0]}, w[WORD_W-1:0]);
      push(1'b1, 1'b1, a[1], r[21:0], '0);
    end
    group_done("preload");
    // Back-to-back reads, half with both selects low, then write and read in alternation.
    for (i = 0; i < 8; i++) push(1'b0, i[0], i[1], 22'(i), '0);
    for (i = 0; i < 8; i++) begin
      w = {xs(), xs(), xs()};
      push(1'b1, 1'b0, i[0], 22'h3FFF40 + 22'(i), w[WORD_W-1:0]);
      push(1'b0, 1'b1, i[1], 22'(8 + i), '0);
    end
    group_done("ordering");
    // Random traffic; write after write and reads of fresh words are turned aside.
    for (i = 0; i < 300; i++) begin
      r = xs();
      w = {xs(), xs(), xs()};
      a = int'(r[7:0]);
      rn = r[8];
      wn = r[9];
      if (!rn && n_cmd - last_wr[a] < 6) rn = 1'b1;
      if (rn && !wn && pw) wn = 1'b1;
      pw = rn && !wn;
      push(rn, wn, r[10], {r[29:16], r[7:0]}, w[WORD_W-1:0]);
    end
    group_done("random");
    check("fifo word count", 96'(got), 96'(n_wr));
    check("fifo drained", 96'(uut.drain_vld), 96'(0));
    end_sim();
  end
endmodule
